// File: ranging_consts.svh
`ifndef RANGING_CONSTS_SVH
`define RANGING_CONSTS_SVH
`define OFF_MAIN_ADDR   8'h8C
`define OFF_CMP_RANGE   8'h8D
`define OFF_SHIFT_12    8'h8E
`define OFF_SHIFT_34    8'h8F
`define RST_MAIN_ADDR   8'h00
`define RST_CMP_RANGE   8'h00
`define RST_SHIFT_12    8'h00
`define RST_SHIFT_34    8'h30
`define FIXED_MAIN_ADDR 8'hA2
`define AUX_ADDR        8'hA0
`define HI_FIELD_MSB    6
`define HI_FIELD_LSB    4
`define LO_FIELD_MSB    2
`define LO_FIELD_LSB    0
`define FIELD_MASK      8'h77
`define UNMAPPED_READ   8'h00
`define RST_RD_DATA     8'h00
`define RST_RANGE       3'h0
`define AUX_ON          1'b1
`define RST_MON_WORD    16'h0000
`define TOP_CODE        3'h7
`define WR_SETTLE       2
`endif

// File: ranging_pkg.sv
package ranging_pkg;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_t;
    typedef logic [15:0] mon_word_t;
endpackage : ranging_pkg

// File: monitor_ranging_address_config.sv
`timescale 1ns/100ps
`include "ranging_consts.svh"
module monitor_ranging_address_config
    import ranging_pkg::*;
(
    input  wire logic      sys_clk_i,
    input  wire logic      rst_n_i,
    input  wire reg_req_t  req_i,
    input  wire logic      main_addr_select_i,
    input  wire mon_word_t mon_raw_i [4],
    output logic [7:0]     rd_data_o,
    output logic [7:0]     main_slave_addr_o,
    output logic           aux_mem_enable_o,
    output logic [2:0]     bias_trip_range_o,
    output logic [2:0]     power_loop_trip_range_o,
    output logic [2:0]     power_loop_ctrl_range_o,
    output mon_word_t      mon_shifted_o [4]
);
    // Stored configuration bytes, one per offset
    logic [7:0] addr_r;
    logic [7:0] cmp_r;
    logic [7:0] sh12_r;
    logic [7:0] sh34_r;

    // Next values of the stored bytes and of the read data
    logic [7:0] addr_nxt;
    logic [7:0] cmp_nxt;
    logic [7:0] sh12_nxt;
    logic [7:0] sh34_nxt;
    logic [7:0] rd_nxt;

    // Next values of the derived outputs
    logic [7:0] slave_addr_nxt;
    logic       aux_enable_nxt;
    logic [2:0] bias_range_nxt;
    logic [2:0] loop_range_nxt;
    mon_word_t  shifted_nxt [4];

    // Shift amount per monitor channel
    logic [2:0] shamt [4];

    // Register writes; reserved bits are held at zero
    always_comb begin
        addr_nxt = addr_r;
        cmp_nxt  = cmp_r;
        sh12_nxt = sh12_r;
        sh34_nxt = sh34_r;
        if (req_i.wr) begin
            if (req_i.addr == `OFF_MAIN_ADDR) begin
                addr_nxt = req_i.data;
            end else if (req_i.addr == `OFF_CMP_RANGE) begin
                cmp_nxt = req_i.data & `FIELD_MASK;
            end else if (req_i.addr == `OFF_SHIFT_12) begin
                sh12_nxt = req_i.data & `FIELD_MASK;
            end else if (req_i.addr == `OFF_SHIFT_34) begin
                sh34_nxt = req_i.data & `FIELD_MASK;
            end
        end
    end

    // Read mux; other offsets read zero
    always_comb begin
        rd_nxt = `UNMAPPED_READ;
        if (req_i.addr == `OFF_MAIN_ADDR) begin
            rd_nxt = addr_r;
        end else if (req_i.addr == `OFF_CMP_RANGE) begin
            rd_nxt = cmp_r;
        end else if (req_i.addr == `OFF_SHIFT_12) begin
            rd_nxt = sh12_r;
        end else if (req_i.addr == `OFF_SHIFT_34) begin
            rd_nxt = sh34_r;
        end
    end

    // Configuration bytes and read data; reset loads the factory values
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            addr_r    <= `RST_MAIN_ADDR;
            cmp_r     <= `RST_CMP_RANGE;
            sh12_r    <= `RST_SHIFT_12;
            sh34_r    <= `RST_SHIFT_34;
            rd_data_o <= `RST_RD_DATA;
        end else begin
            addr_r    <= addr_nxt;
            cmp_r     <= cmp_nxt;
            sh12_r    <= sh12_nxt;
            sh34_r    <= sh34_nxt;
            rd_data_o <= rd_nxt;
        end
    end

    // A write followed at once by a read of the same shift byte returns
    // the masked value; reserved bits always read as zero
    rd_back_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (req_i.wr && req_i.addr == `OFF_SHIFT_12) ##1
        (!req_i.wr && req_i.addr == `OFF_SHIFT_12)
        |=> rd_data_o == ($past(req_i.data, `WR_SETTLE) & `FIELD_MASK))
        else $error("readback wrong");

    // Shift amounts per channel
    assign shamt[0] = sh12_r[`HI_FIELD_MSB:`HI_FIELD_LSB];
    assign shamt[1] = sh12_r[`LO_FIELD_MSB:`LO_FIELD_LSB];
    assign shamt[2] = sh34_r[`HI_FIELD_MSB:`HI_FIELD_LSB];
    assign shamt[3] = sh34_r[`LO_FIELD_MSB:`LO_FIELD_LSB];

    // Derived outputs follow the stored bytes one edge later, so a write
    // shows on them one edge after it is taken
    always_comb begin
        slave_addr_nxt = `FIXED_MAIN_ADDR;
        if (main_addr_select_i) begin
            slave_addr_nxt = addr_r;
        end
        aux_enable_nxt = (addr_r != `AUX_ADDR);
        bias_range_nxt = cmp_r[`HI_FIELD_MSB:`HI_FIELD_LSB];
        loop_range_nxt = cmp_r[`LO_FIELD_MSB:`LO_FIELD_LSB];
    end

    // One power loop code feeds trip and loop, so the two never differ
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            main_slave_addr_o       <= `FIXED_MAIN_ADDR;
            aux_mem_enable_o        <= `AUX_ON;
            bias_trip_range_o       <= `RST_RANGE;
            power_loop_trip_range_o <= `RST_RANGE;
            power_loop_ctrl_range_o <= `RST_RANGE;
        end else begin
            main_slave_addr_o       <= slave_addr_nxt;
            aux_mem_enable_o        <= aux_enable_nxt;
            bias_trip_range_o       <= bias_range_nxt;
            power_loop_trip_range_o <= loop_range_nxt;
            power_loop_ctrl_range_o <= loop_range_nxt;
        end
    end

    // Address select picks the programmed byte, otherwise the fixed one
    addr_sel_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        main_addr_select_i |=> main_slave_addr_o == $past(addr_r))
        else $error("programmed address not used");
    addr_fix_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !main_addr_select_i |=> main_slave_addr_o == `FIXED_MAIN_ADDR)
        else $error("fixed address not used");

    // Auxiliary memory is off one edge after the address byte holds A0h, and on one edge after it holds any other value
    aux_off_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (addr_r == `AUX_ADDR) |=> !aux_mem_enable_o)
        else $error("aux memory not disabled");
    aux_on_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (addr_r != `AUX_ADDR) |=> aux_mem_enable_o)
        else $error("aux memory not enabled");

    // A range write reaches the bias trip output two edges later
    bias_rng_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (req_i.wr && req_i.addr == `OFF_CMP_RANGE) |=> ##1
        bias_trip_range_o
            == $past(req_i.data[`HI_FIELD_MSB:`HI_FIELD_LSB], `WR_SETTLE))
        else $error("bias range wrong");

    // Both power loop outputs carry the low code of the range byte
    apc_rng_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        power_loop_trip_range_o == power_loop_ctrl_range_o
        && power_loop_trip_range_o
            == $past(cmp_r[`LO_FIELD_MSB:`LO_FIELD_LSB]))
        else $error("power loop range mismatch");

    // Zero-filled logical shift, one lane per channel; the result is
    // registered, so a new shift field shows one edge after the byte
    for (genvar g = 0; g < 4; g++) begin : g_shift
        always_comb begin
            shifted_nxt[g] = mon_raw_i[g] >> shamt[g];
        end

        always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mon_shifted_o[g] <= `RST_MON_WORD;
            end else begin
                mon_shifted_o[g] <= shifted_nxt[g];
            end
        end
    end

    // Lanes follow their own shift field one edge late; the first edge
    // after reset still shows cleared lanes, so it is not judged
    sh1_val_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> mon_shifted_o[0]
            == $past(mon_raw_i[0])
               >> $past(sh12_r[`HI_FIELD_MSB:`HI_FIELD_LSB]))
        else $error("channel 1 shift wrong");
    sh2_val_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> mon_shifted_o[1]
            == $past(mon_raw_i[1])
               >> $past(sh12_r[`LO_FIELD_MSB:`LO_FIELD_LSB]))
        else $error("channel 2 shift wrong");
    sh3_val_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> mon_shifted_o[2]
            == $past(mon_raw_i[2])
               >> $past(sh34_r[`HI_FIELD_MSB:`HI_FIELD_LSB]))
        else $error("channel 3 shift wrong");
    sh4_val_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $past(rst_n_i) |-> mon_shifted_o[3]
            == $past(mon_raw_i[3])
               >> $past(sh34_r[`LO_FIELD_MSB:`LO_FIELD_LSB]))
        else $error("channel 4 shift wrong");
    sh_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (sh34_r[`HI_FIELD_MSB:`HI_FIELD_LSB] == `TOP_CODE)
        |=> (mon_shifted_o[2] >> ($bits(mon_word_t) - `TOP_CODE))
            == 16'h0000)
        else $error("shift not zero filled");

    // Main scenarios: auxiliary memory off, programmed address in use,
    // deepest shift on a lane, top bias code, write then readback
    aux_c: cover property (@(posedge sys_clk_i) !aux_mem_enable_o);
    sel_c: cover property (@(posedge sys_clk_i) main_addr_select_i
        && addr_r != `RST_MAIN_ADDR);
    shift_c: cover property (@(posedge sys_clk_i) shamt[1] == `TOP_CODE);
    range_c: cover property (@(posedge sys_clk_i)
        bias_trip_range_o == `TOP_CODE);
    back_c: cover property (@(posedge sys_clk_i)
        req_i.wr ##1 (!req_i.wr && req_i.addr == `OFF_SHIFT_12));
endmodule : monitor_ranging_address_config

// File: host_model.sv
`timescale 1ns/100ps
module host_model
    import ranging_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic [7:0] rd_data_i,
    output reg_req_t        req_o
);
    initial req_o = '0;
    // One-edge write strobe; data then inverted so stale bytes never match
    task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        req_o <= '{1'b1, a, d};
        @(posedge sys_clk_i);
        req_o <= '{1'b0, a, ~d};
    endtask : wr_byte
    // Read data lands one edge after the address is shown
    task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        req_o <= '{1'b0, a, ~a};
        @(posedge sys_clk_i);
        #1 d = rd_data_i;
    endtask : rd_byte
endmodule : host_model

// File: monitor_ranging_address_config_tb_top.sv
`timescale 1ns/100ps
module monitor_ranging_address_config_tb_top
    import ranging_pkg::*;
;
    logic       sys_clk_i = 1'b0;
    logic       rst_n_i   = 1'b0;
    logic       sel_r     = 1'b0;
    reg_req_t   req;
    logic [7:0] rd, slv, v, d;
    logic       aux;
    logic [2:0] bias, ptrip, pctrl;
    mon_word_t  raw [4];
    mon_word_t  shf [4];
    int         mismatches = 0;
    int         checked = 0;
    int         cycles = 0;
    initial forever #50 sys_clk_i = ~sys_clk_i;
    initial raw = '{16'hF0F0, 16'hFFFF, 16'h8001, 16'h1234};
    monitor_ranging_address_config u_monitor_ranging_address_config (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req),
        .main_addr_select_i(sel_r), .mon_raw_i(raw), .rd_data_o(rd),
        .main_slave_addr_o(slv), .aux_mem_enable_o(aux),
        .bias_trip_range_o(bias), .power_loop_trip_range_o(ptrip),
        .power_loop_ctrl_range_o(pctrl), .mon_shifted_o(shf));
    host_model u_host_model (
        .sys_clk_i(sys_clk_i), .rd_data_i(rd), .req_o(req));
    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Write, then read the byte back
    task automatic wrd(input logic [7:0] a, input logic [7:0] w,
                       input logic [7:0] e);
        u_host_model.wr_byte(a, w);
        u_host_model.rd_byte(a, v);
        chk("readback", 16'(e), 16'(v));
    endtask : wrd
    task automatic close_out();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    // Hang guard: whole run needs about 130 cycles
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            u_host_model.rd_byte(8'h8C + 8'(i), v);
            chk("reset", i == 3 ? 16'h0030 : 16'h0000, 16'(v));
        end
        chk("fixed addr", 16'h00A2, 16'(slv));
        $display("reset test done");
        // Reserved bits set on purpose in the 8Dh and 8Eh writes; every code of each field
        for (int k = 0; k < 8; k++) begin
            d = {1'b1, 3'(k), 1'b1, 3'(7 - k)};
            wrd(8'h8D, d, d & 8'h77);
            wrd(8'h8E, d, d & 8'h77);
            wrd(8'h8F, ~d, ~d);
            chk("bias", 16'(k), 16'(bias));
            chk("trip", 16'(7 - k), 16'(ptrip));
            chk("loop", 16'(7 - k), 16'(pctrl));
            chk("ch1", raw[0] >> k, shf[0]);
            chk("ch2", raw[1] >> (7 - k), shf[1]);
            chk("ch3", raw[2] >> (7 - k), shf[2]);
            chk("ch4", raw[3] >> k, shf[3]);
        end
        $display("range and shift test done");
        wrd(8'h8C, 8'hA0, 8'hA0);
        chk("aux", 16'h0000, 16'(aux));
        chk("fixed addr", 16'h00A2, 16'(slv));
        @(posedge sys_clk_i);
        sel_r <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1 chk("main addr", 16'h00A0, 16'(slv));
        wrd(8'h8C, 8'h5A, 8'h5A);
        chk("main addr", 16'h005A, 16'(slv));
        chk("aux", 16'h0001, 16'(aux));
        wrd(8'h90, 8'hFF, 8'h00);
        $display("address test done");
        close_out();
    end
endmodule : monitor_ranging_address_config_tb_top
